// ==== design/pwmif_pkg.sv ====
// Notes on behaviour
// - Unit one pending flag sits at bit 4, units two to four at bits 5 to 7.
// - A flag bit reads one while its unit has an interrupt pending, else zero.
// - Flags are read-only here; only clearing inside the originating unit clears them.
// - A flag sets on its condition regardless of per-source or global enable.
// - Bits 3 to 0 are unimplemented and always read zero.
package pwmif_pkg;
   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [11:0] PWMIF_PENDING_OFS = 12'h000;
   localparam logic [11:0] PWMIF_MASK_OFS = 12'h004;
   localparam logic [11:0] PWMIF_STATUS_OFS = 12'h008;
   localparam int PWMIF_UNITS = 4;
   localparam int PWMIF_FLAG_LSB = 4;
   localparam logic [7:0] PWMIF_PENDING_RST = 8'h00;
   localparam logic [3:0] PWMIF_MASK_RST = 4'h0;
   localparam logic [1:0] PWMIF_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] PWMIF_HTRANS_SEQ = 2'h3;

   typedef struct packed {
      logic sel;
      logic write;
      logic [11:0] addr;
   } pwmif_req_s;
endpackage : pwmif_pkg

// ==== design/pwmif_ahb_slave.sv ====
`timescale 1ns/1ps
// ****************************************************
// AHB-Lite slave front end, zero wait states
// ****************************************************
module pwmif_ahb_slave
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   output pwmif_pkg::pwmif_req_s req
);
   import pwmif_pkg::*;
   pwmif_req_s next_req;

   always_comb
   begin
      next_req.sel = hsel && hready &&
         (htrans == PWMIF_HTRANS_NONSEQ || htrans == PWMIF_HTRANS_SEQ);
      next_req.write = hwrite;
      next_req.addr = haddr[11:0];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         req <= '0;
      else
         req <= next_req;
   end
endmodule : pwmif_ahb_slave

// ==== design/pwmif_flag_bank.sv ====
`timescale 1ns/1ps
// ****************************************************
// Pending flags mirrored from the PWM units
// ****************************************************
module pwmif_flag_bank
#(
   parameter int UNITS = 4
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [UNITS-1:0] unit_pending,
   output logic [UNITS-1:0] flags
);
   logic [UNITS-1:0] next_flags;

   // Mirror only: no enable gates the flag, and no bus write reaches it
   genvar i;
   generate
      for (i = 0; i < UNITS; i++)
      begin : g_flag
         always_comb
         begin
            next_flags[i] = unit_pending[i];
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flags <= '0;
      else
         flags <= next_flags;
   end

   // Only the unit input moves a flag, one cycle later
   a_flag_mirror: assert property (
      @(posedge hclk) disable iff (!hresetn)
      flags == $past(unit_pending)
   )
   else
      $error("flag does not mirror the unit");
endmodule : pwmif_flag_bank

// ==== design/pwmif_top.sv ====
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// ****************************************************
// PWM interrupt flag register, AHB-Lite slave
// ****************************************************
module pwmif_top
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [pwmif_pkg::PWMIF_UNITS-1:0] unit_pending,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq
);
   import pwmif_pkg::*;

   pwmif_req_s req;
   logic [PWMIF_UNITS-1:0] flags;
   logic [PWMIF_UNITS-1:0] flags_q;
   logic [PWMIF_UNITS-1:0] mask;
   logic [PWMIF_UNITS-1:0] status;
   logic [PWMIF_UNITS-1:0] next_mask;
   logic [PWMIF_UNITS-1:0] next_status;
   logic [31:0] next_hrdata;
   logic next_irq;
   logic [7:0] pending_byte;
   logic rd_take;

   pwmif_ahb_slave u_slave
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .req(req)
   );

   pwmif_flag_bank #(.UNITS(PWMIF_UNITS)) u_flags
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .unit_pending(unit_pending),
      .flags(flags)
   );

   // ****************************************************
   // Register read and write
   // ****************************************************
   always_comb
   begin
      pending_byte = {flags, 4'h0};
      next_mask = mask;
      next_status = status | (flags & ~flags_q);
      next_hrdata = hrdata;
      if (req.sel && req.write)
      begin
         // Pending register ignores writes; flags clear only in the units
         if (req.addr == PWMIF_MASK_OFS)
            next_mask = hwdata[PWMIF_UNITS-1:0];
         if (req.addr == PWMIF_STATUS_OFS)
            next_status = (status & ~hwdata[PWMIF_UNITS-1:0]) | (flags & ~flags_q);
      end
      // Decode the live address phase so read data stands in the data phase
      rd_take = hsel && hready && !hwrite &&
         (htrans == PWMIF_HTRANS_NONSEQ || htrans == PWMIF_HTRANS_SEQ);
      if (rd_take)
      begin
         unique case (haddr[11:0])
            PWMIF_PENDING_OFS: next_hrdata = {24'h000000, pending_byte};
            PWMIF_MASK_OFS: next_hrdata = {28'h0000000, mask};
            PWMIF_STATUS_OFS: next_hrdata = {28'h0000000, status};
            default: next_hrdata = 32'h00000000;
         endcase
      end
      next_irq = |(next_status & next_mask);
   end

   // Read data registered at the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mask <= PWMIF_MASK_RST;
         status <= '0;
         flags_q <= '0;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         mask <= next_mask;
         status <= next_status;
         flags_q <= flags;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= next_irq;
      end
   end

   // ****************************************************
   // Bus response checks
   // ****************************************************
   // Zero wait states: the slave never stretches a transfer
   a_okay_response: assert property (
      @(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp
   )
   else
      $error("bus response not ready or not okay");

   // Read data must hold through the data phase of the last read
   a_hrdata_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !rd_take |=> $stable(hrdata)
   )
   else
      $error("read data changed without a read");

   // ****************************************************
   // Read map checks
   // ****************************************************
   // Flags sit in the upper nibble, the lower nibble reads zero
   a_pending_map: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_take && haddr[11:0] == PWMIF_PENDING_OFS
      |=> hrdata == {24'h000000, $past(flags), 4'h0}
   )
   else
      $error("pending read does not match the flags");

   a_mask_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_take && haddr[11:0] == PWMIF_MASK_OFS
      |=> hrdata == {28'h0000000, $past(mask)}
   )
   else
      $error("mask read does not match the mask");

   a_status_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_take && haddr[11:0] == PWMIF_STATUS_OFS
      |=> hrdata == {28'h0000000, $past(status)}
   )
   else
      $error("status read does not match the status");

   // Unmapped words read as zero so software sees no stale data
   a_unmapped_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_take && haddr[11:0] != PWMIF_PENDING_OFS &&
      haddr[11:0] != PWMIF_MASK_OFS && haddr[11:0] != PWMIF_STATUS_OFS
      |=> hrdata == 32'h00000000
   )
   else
      $error("unmapped read not zero");

   // ****************************************************
   // Status, mask and interrupt checks
   // ****************************************************
   // A flag edge sets status whatever the mask holds
   a_status_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      |(flags & ~flags_q)
      |=> (status & $past(flags & ~flags_q)) == $past(flags & ~flags_q)
   )
   else
      $error("flag edge did not set status");

   // Write one to clear; a new edge in the same cycle wins
   a_status_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      req.sel && req.write && req.addr == PWMIF_STATUS_OFS
      |=> status == (($past(status) & ~$past(hwdata[PWMIF_UNITS-1:0]))
                     | $past(flags & ~flags_q))
   )
   else
      $error("status clear wrong");

   a_mask_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      req.sel && req.write && req.addr == PWMIF_MASK_OFS
      |=> mask == $past(hwdata[PWMIF_UNITS-1:0])
   )
   else
      $error("mask write lost");

   // Registered from the next values, so irq tracks status and mask exactly
   a_irq_level: assert property (
      @(posedge hclk) disable iff (!hresetn)
      irq == |(status & mask)
   )
   else
      $error("irq does not follow masked status");

   // ****************************************************
   // Reset checks
   // ****************************************************
   // No disable here: the check is about the reset itself
   a_reset_clear: assert property (
      @(posedge hclk)
      $rose(hresetn) |-> flags == '0 && status == '0 && irq == 1'b0 &&
      hrdata == 32'h00000000
   )
   else
      $error("state not clear after reset");
endmodule : pwmif_top

// ==== tb/pwmif_unit_model.sv ====
`timescale 1ns/1ps
// ****
// Four PWM units, each holding its own flag
// ****
module pwmif_unit_model
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] raise,
   input wire logic [3:0] clear,
   output logic [3:0] pending
);
   // Only the unit can clear its flag
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         pending <= 4'h0;
      else
         pending <= (pending | raise) & ~clear;
endmodule : pwmif_unit_model

// ==== tb/pwmif_top_tb.sv ====
`timescale 1ns/1ps
module pwmif_top_tb;
   import pwmif_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [3:0] raise = 4'h0, clear = 4'h0, pending;
   int errors = 0, compares = 0;
   always #5 hclk = ~hclk;
   pwmif_unit_model pwmif_unit_model_i (.hclk(hclk), .hresetn(hresetn), .raise(raise),
      .clear(clear), .pending(pending));
   pwmif_top pwmif_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .unit_pending(pending), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : check
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= PWMIF_HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0);
      check(n, r, e);
   endtask : rd
   // Wait covers flag, status and irq register stages
   task automatic poke(input logic [3:0] rs, input logic [3:0] cl);
      @(posedge hclk);
      raise <= rs;
      clear <= cl;
      @(posedge hclk);
      raise <= 4'h0;
      clear <= 4'h0;
      repeat (4) @(posedge hclk);
   endtask : poke
   task automatic final_report;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // ****
   // Tests
   // ****
   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd(PWMIF_PENDING_OFS, 32'h0, "pending");
      rd(PWMIF_MASK_OFS, 32'h0, "mask");
      rd(PWMIF_STATUS_OFS, 32'h0, "status");
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         poke(4'h1 << i, 4'h0);
         rd(PWMIF_PENDING_OFS, 32'h10 << i, "pending set");
         xfer(1'b1, PWMIF_PENDING_OFS, 32'hFFFF_FFFF);
         rd(PWMIF_PENDING_OFS, 32'h10 << i, "pending ro");
         check("irq masked", {31'h0, irq}, 32'h0);
         poke(4'h0, 4'h1 << i);
         rd(PWMIF_PENDING_OFS, 32'h0, "pending clr");
      end
      $display("test flags done");
      xfer(1'b1, PWMIF_STATUS_OFS, 32'hF);
      xfer(1'b1, PWMIF_MASK_OFS, 32'h1);
      poke(4'h3, 4'h0);
      check("irq", {31'h0, irq}, 32'h1);
      rd(PWMIF_STATUS_OFS, 32'h3, "status");
      rd(PWMIF_PENDING_OFS, 32'h30, "pending both");
      xfer(1'b1, PWMIF_STATUS_OFS, 32'h1);
      repeat (3) @(posedge hclk);
      check("irq clr", {31'h0, irq}, 32'h0);
      rd(12'h00C, 32'h0, "unmapped");
      $display("test irq done");
      final_report();
   end
   initial
   begin
      #50000;
      errors++;
      final_report();
   end
endmodule : pwmif_top_tb
